/* include/rtc_pkg.sv */
package rtc_pkg;
    // ********************************
    // word format
    // ********************************
    localparam int rtc_word_bits = 32;
    localparam int rtc_code_bits = 5;
    localparam int rtc_reg_count = 8;
    localparam logic [4:0] rtc_code_power = 5'h00;
    localparam logic [4:0] rtc_code_level = 5'h01;
    localparam logic [4:0] rtc_code_conv = 5'h02;
    localparam logic [4:0] rtc_code_select = 5'h03;
    localparam logic [4:0] rtc_code_test = 5'h04;
    localparam logic [4:0] rtc_code_ramp = 5'h05;
    localparam logic [4:0] rtc_code_subunit_divide_word_low = 5'h06;
    localparam logic [4:0] rtc_code_reset = 5'h07;
    localparam logic [31:0] rtc_reg_reset = 32'h0000_0000;
    // ********************************
    // field positions
    // ********************************
    localparam int rtc_bit_out_two_cal = 12;
    localparam int rtc_bit_out_one_cal = 11;
    localparam int rtc_bit_osc_on = 10;
    localparam int rtc_bit_osc_cal = 9;
    localparam int rtc_bit_conv_on = 8;
    localparam int rtc_bit_out_two_on = 7;
    localparam int rtc_bit_out_one_on = 6;
    localparam int rtc_bit_lo_on = 5;
    localparam int rtc_level_lsb = 5;
    localparam int rtc_bit_conv_start = 15;
    localparam int rtc_avg_lsb = 13;
    localparam int rtc_conv_div_lsb = 5;
    localparam int rtc_mux_lsb = 12;
    localparam int rtc_bit_io_level = 11;
    localparam int rtc_readback_lsb = 5;
    localparam int rtc_test_lsb = 5;
    localparam int rtc_bit_ramp_on = 29;
    localparam int rtc_int_lsb = 17;
    localparam int rtc_subunit_divide_word_high_lsb = 5;
    localparam int rtc_subunit_divide_word_low_lsb = 5;
    localparam int rtc_bit_master_reset = 25;
    localparam int rtc_step_div_lsb = 12;
    localparam logic [3:0] rtc_mux_low = 4'h0;
    localparam logic [3:0] rtc_mux_high = 4'h1;
    localparam logic [3:0] rtc_mux_conv_tick = 4'h2;
    localparam logic [3:0] rtc_mux_step_tick = 4'h3;
    localparam logic [3:0] rtc_mux_ramp_status = 4'hf;
    localparam logic [5:0] rtc_readback_status = 6'h08;
    // ********************************
    // carriers
    // ********************************
    typedef struct packed {
        logic osc_power_on;
        logic converter_power_on;
        logic out_one_power_on;
        logic out_two_power_on;
        logic local_osc_out_power_on;
    } rtc_power_type;
    typedef struct packed {
        logic out_one_level_cal;
        logic out_two_level_cal;
        logic osc_calibrate;
        logic converter_start;
    } rtc_start_type;
    typedef struct packed {
        logic [26:0] data;
        logic [4:0] target_select_code;
    } rtc_word_type;
endpackage

/* logic/rtc_serial_rx.sv */
`timescale 1ns/100ps
module rtc_serial_rx (
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_enable,
    output rtc_pkg::rtc_word_type word,
    output logic word_valid,
    output logic clk_fall
);
    // ********************************
    // pin synchronisers
    // ********************************
    logic [2:0] meta;
    logic [2:0] sync;
    logic sclk_last;
    logic le_last;
    logic [31:0] shift;
    wire sclk_rise = sync[0] & ~sclk_last;
    wire sclk_fall = ~sync[0] & sclk_last;
    wire le_rise = sync[2] & ~le_last;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 3'h0;
            sync <= 3'h0;
            sclk_last <= 1'b0;
            le_last <= 1'b0;
        end else begin
            meta <= {load_enable, serial_data, serial_clk};
            sync <= meta;
            sclk_last <= sync[0];
            le_last <= sync[2];
        end
    end

    // ********************************
    // shifter
    // ********************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift <= 32'h0000_0000;
            word <= '0;
            word_valid <= 1'b0;
            clk_fall <= 1'b0;
        end else begin
            if (sclk_rise) begin
                shift <= {shift[30:0], sync[1]};
            end
            word_valid <= le_rise;
            if (le_rise) begin
                word <= shift;
            end
            clk_fall <= sclk_fall;
        end
    end
endmodule

/* logic/rtc_ctrl_regs.sv */
`timescale 1ns/100ps
module rtc_ctrl_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_enable,
    input wire logic trigger_pin,
    input wire logic ref_div_tick,
    input wire logic pfd_tick,
    output logic readback_data_out,
    output logic readback_level_high,
    output logic diag_select_pin,
    output logic analog_probe_pin_enable,
    output rtc_pkg::rtc_power_type power,
    output rtc_pkg::rtc_start_type start,
    output logic [7:0] level_cal_target,
    output logic [1:0] converter_average,
    output logic converter_sample_tick,
    output logic [14:0] test_bus_select,
    output logic ramp_on,
    output logic ramp_return_initial,
    output logic [11:0] int_divide_word,
    output logic [24:0] subunit_divide_word,
    output logic device_soft_reset,
    output logic [11:0] cal_timestep_divider,
    output logic cal_timestep_tick
);
    // ********************************
    // divider step
    // ********************************
    // returns {wrap, next count}; a divide value of zero acts as one
    function automatic logic [12:0] rtc_div_step(
        input logic [11:0] count,
        input logic [11:0] divide
    );
        logic [11:0] plus_one;
        plus_one = count + 12'h001;
        if (plus_one >= divide) begin
            rtc_div_step = {1'b1, 12'h000};
        end else begin
            rtc_div_step = {1'b0, plus_one};
        end
    endfunction

    // ********************************
    // serial receiver
    // ********************************
    rtc_pkg::rtc_word_type rx_word;
    logic rx_valid;
    logic rx_clk_fall;

    rtc_serial_rx u_rx (
        .clk(clk),
        .rst(rst),
        .serial_clk(serial_clk),
        .serial_data(serial_data),
        .load_enable(load_enable),
        .word(rx_word),
        .word_valid(rx_valid),
        .clk_fall(rx_clk_fall)
    );

    // ********************************
    // write decode
    // ********************************
    logic [31:0] regs [0:7];
    logic soft_rst;
    logic [12:0] subunit_divide_word_low_pending;
    logic [31:0] wr_data;
    logic [4:0] wr_code;
    logic in_range;
    logic wr_power;
    logic wr_conv;
    logic wr_ramp;
    logic wr_subunit_divide_word_low;
    logic wr_reset;
    logic accept;

    assign wr_data = rx_word;
    assign wr_code = rx_word.target_select_code;
    // codes above seven belong to other blocks
    assign in_range = wr_code < 5'(rtc_pkg::rtc_reg_count);
    // while master reset is held only its own word is taken
    assign accept = rx_valid & in_range &
        (~soft_rst | (wr_code == rtc_pkg::rtc_code_reset));
    assign wr_power = accept & (wr_code == rtc_pkg::rtc_code_power);
    assign wr_conv = accept & (wr_code == rtc_pkg::rtc_code_conv);
    assign wr_ramp = accept & (wr_code == rtc_pkg::rtc_code_ramp);
    assign wr_subunit_divide_word_low = accept & (wr_code == rtc_pkg::rtc_code_subunit_divide_word_low);
    assign wr_reset = accept & (wr_code == rtc_pkg::rtc_code_reset);

    // ********************************
    // register store
    // ********************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < rtc_pkg::rtc_reg_count; i++) begin
                regs[i] <= rtc_pkg::rtc_reg_reset;
            end
        end else if (soft_rst & ~wr_reset) begin
            for (int i = 0; i < rtc_pkg::rtc_reg_count; i++) begin
                regs[i] <= rtc_pkg::rtc_reg_reset;
            end
        end else if (accept) begin
            regs[wr_code[2:0]] <= wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            soft_rst <= 1'b0;
        end else if (wr_reset) begin
            soft_rst <= wr_data[rtc_pkg::rtc_bit_master_reset];
        end
    end

    // ********************************
    // field views
    // ********************************
    logic [31:0] r_power;
    logic [31:0] r_level;
    logic [31:0] r_conv;
    logic [31:0] r_select;
    logic [31:0] r_test;
    logic [31:0] r_ramp;
    logic [31:0] r_step;
    logic [3:0] mux_select;
    logic [5:0] readback_select;
    logic [14:0] test_field;
    logic [11:0] conv_divide;
    logic [11:0] step_divide;
    logic [12:0] subunit_divide_word_low_field;

    assign r_power = regs[0];
    assign r_level = regs[1];
    assign r_conv = regs[2];
    assign r_select = regs[3];
    assign r_test = regs[4];
    assign r_ramp = regs[5];
    assign r_step = regs[7];
    assign mux_select = r_select[rtc_pkg::rtc_mux_lsb +: 4];
    assign readback_select =
        r_select[rtc_pkg::rtc_readback_lsb +: 6];
    assign test_field = r_test[rtc_pkg::rtc_test_lsb +: 15];
    assign conv_divide =
        {4'h0, r_conv[rtc_pkg::rtc_conv_div_lsb +: 8]};
    assign step_divide = r_step[rtc_pkg::rtc_step_div_lsb +: 12];
    assign subunit_divide_word_low_field = wr_data[rtc_pkg::rtc_subunit_divide_word_low_lsb +: 13];

    // ********************************
    // control outputs
    // ********************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power <= '0;
            level_cal_target <= 8'h00;
            converter_average <= 2'h0;
            test_bus_select <= 15'h0000;
            analog_probe_pin_enable <= 1'b0;
            readback_level_high <= 1'b0;
            int_divide_word <= 12'h000;
            device_soft_reset <= 1'b0;
            cal_timestep_divider <= 12'h000;
        end else begin
            power.osc_power_on <=
                r_power[rtc_pkg::rtc_bit_osc_on];
            power.converter_power_on <=
                r_power[rtc_pkg::rtc_bit_conv_on];
            // both outputs are passed as written; exclusivity is the host's
            power.out_one_power_on <=
                r_power[rtc_pkg::rtc_bit_out_one_on];
            power.out_two_power_on <=
                r_power[rtc_pkg::rtc_bit_out_two_on];
            power.local_osc_out_power_on <=
                r_power[rtc_pkg::rtc_bit_lo_on];
            level_cal_target <=
                r_level[rtc_pkg::rtc_level_lsb +: 8];
            converter_average <=
                r_conv[rtc_pkg::rtc_avg_lsb +: 2];
            test_bus_select <= test_field;
            analog_probe_pin_enable <= test_field != 15'h0000;
            readback_level_high <= r_select[rtc_pkg::rtc_bit_io_level];
            int_divide_word <= r_ramp[rtc_pkg::rtc_int_lsb +: 12];
            device_soft_reset <= soft_rst;
            cal_timestep_divider <= step_divide;
        end
    end

    // ********************************
    // start pulses
    // ********************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start <= '0;
        end else begin
            start.out_two_level_cal <= wr_power &
                wr_data[rtc_pkg::rtc_bit_out_two_cal];
            start.out_one_level_cal <= wr_power &
                wr_data[rtc_pkg::rtc_bit_out_one_cal];
            start.osc_calibrate <= wr_power &
                wr_data[rtc_pkg::rtc_bit_osc_cal];
            start.converter_start <= wr_conv &
                wr_data[rtc_pkg::rtc_bit_conv_start];
        end
    end

    // ********************************
    // fractional word, double buffered
    // ********************************
    // low bits wait until the next high-word write so both halves
    // change in the same cycle and no mixed word reaches the loop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            subunit_divide_word_low_pending <= 13'h0000;
            subunit_divide_word <= 25'h000_0000;
        end else if (soft_rst) begin
            subunit_divide_word_low_pending <= 13'h0000;
            subunit_divide_word <= 25'h000_0000;
        end else begin
            if (wr_subunit_divide_word_low) begin
                subunit_divide_word_low_pending <= subunit_divide_word_low_field;
            end
            if (wr_ramp) begin
                subunit_divide_word <= {
                    wr_data[rtc_pkg::rtc_subunit_divide_word_high_lsb +: 12],
                    subunit_divide_word_low_pending};
            end
        end
    end

    // ********************************
    // ramp run and stop
    // ********************************
    logic [1:0] trig_meta;
    logic trig_sync;
    logic trig_last;
    logic trig_off;
    logic initial_armed;
    logic ramp_bit;

    assign trig_off = ~trig_sync & trig_last;
    assign ramp_bit = wr_data[rtc_pkg::rtc_bit_ramp_on];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_meta <= 2'h0;
            trig_sync <= 1'b0;
            trig_last <= 1'b0;
        end else begin
            trig_meta <= {trig_meta[0], trigger_pin};
            trig_sync <= trig_meta[1];
            trig_last <= trig_sync;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ramp_on <= 1'b0;
            initial_armed <= 1'b0;
            ramp_return_initial <= 1'b0;
        end else if (soft_rst) begin
            ramp_on <= 1'b0;
            initial_armed <= 1'b0;
            ramp_return_initial <= 1'b0;
        end else begin
            // a written stop lands on the initial frequency only if armed first; a trigger stop always does
            if (wr_subunit_divide_word_low) begin
                initial_armed <= 1'b1;
            end else if (wr_ramp & ~ramp_bit) begin
                initial_armed <= 1'b0;
            end
            if (wr_ramp) begin
                ramp_on <= ramp_bit;
            end else if (trig_off & ramp_on) begin
                ramp_on <= 1'b0;
            end
            ramp_return_initial <= (trig_off & ramp_on & ~wr_ramp) |
                (wr_ramp & ~ramp_bit & ramp_on &
                initial_armed);
        end
    end

    // ********************************
    // clock dividers
    // ********************************
    logic [11:0] conv_count;
    logic [11:0] step_count;
    logic [12:0] conv_step;
    logic [12:0] time_step;

    assign conv_step = rtc_div_step(conv_count, conv_divide);
    assign time_step = rtc_div_step(step_count, step_divide);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_count <= 12'h000;
            step_count <= 12'h000;
            converter_sample_tick <= 1'b0;
            cal_timestep_tick <= 1'b0;
        end else begin
            if (ref_div_tick) begin
                conv_count <= conv_step[11:0];
            end
            if (pfd_tick) begin
                step_count <= time_step[11:0];
            end
            converter_sample_tick <= ref_div_tick & conv_step[12];
            cal_timestep_tick <= pfd_tick & time_step[12];
        end
    end

    // ********************************
    // diagnostic pin
    // ********************************
    logic ramp_status;
    logic diag_next;

    // ramp status only leaves through the top select code
    assign ramp_status = ramp_on & (test_field != 15'h0000);
    assign diag_next =
        (mux_select == rtc_pkg::rtc_mux_high) ? 1'b1 :
        (mux_select == rtc_pkg::rtc_mux_conv_tick) ? converter_sample_tick :
        (mux_select == rtc_pkg::rtc_mux_step_tick) ? cal_timestep_tick :
        (mux_select == rtc_pkg::rtc_mux_ramp_status) ? ramp_status :
        1'b0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            diag_select_pin <= 1'b0;
        end else begin
            diag_select_pin <= diag_next;
        end
    end

    // ********************************
    // readback shifter
    // ********************************
    logic [31:0] readback_source;
    logic [31:0] readback_shift;

    // unknown selects read back as zero
    assign readback_source =
        (readback_select < 6'(rtc_pkg::rtc_reg_count)) ?
            regs[readback_select[2:0]] :
        (readback_select == rtc_pkg::rtc_readback_status) ?
            {26'h000_0000, soft_rst, ramp_on, initial_armed,
            power.osc_power_on, power.out_one_power_on,
            power.out_two_power_on} :
        32'h0000_0000;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readback_shift <= 32'h0000_0000;
            readback_data_out <= 1'b0;
        end else begin
            if (rx_valid) begin
                readback_shift <= readback_source;
            end else if (rx_clk_fall) begin
                readback_shift <= {readback_shift[30:0], 1'b0};
            end
            readback_data_out <= readback_shift[31];
        end
    end
endmodule

/* verif/rtc_host_model.sv */
`timescale 1ns/100ps
module rtc_host_model (
    input wire logic clk,
    output logic serial_clk,
    output logic serial_data,
    output logic load_enable
);
    // ********************************
    // serial host
    // ********************************
    initial begin
        serial_clk = 1'b0; // stands low between frames
        serial_data = 1'b1;
        load_enable = 1'b0;
    end
    // hp is cycles per clock phase, at least three
    task automatic send(input logic [31:0] w, input int hp);
        for (int i = 31; i >= 0; i--) begin
            serial_data = w[i];
            repeat (hp) @(posedge clk);
            #1 serial_clk = 1'b1;
            repeat (hp) @(posedge clk);
            #1 serial_clk = 1'b0;
        end
        // released data line shows the inverse, not a stale bit
        serial_data = ~w[0];
        #0 load_enable = 1'b1;
        repeat (hp) @(posedge clk);
        #1 load_enable = 1'b0;
        repeat (hp) @(posedge clk);
        #1;
    endtask
endmodule

/* verif/rtc_ctrl_regs_sva.sv */
`timescale 1ns/100ps
module rtc_regs_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic load_enable,
    input wire logic trigger_pin,
    input wire logic ref_div_tick,
    input wire logic analog_probe_pin_enable,
    input wire rtc_pkg::rtc_power_type power,
    input wire rtc_pkg::rtc_start_type start,
    input wire logic [7:0] level_cal_target,
    input wire logic converter_sample_tick,
    input wire logic [14:0] test_bus_select,
    input wire logic ramp_on,
    input wire logic ramp_return_initial,
    input wire logic [11:0] int_divide_word,
    input wire logic [24:0] subunit_divide_word,
    input wire logic device_soft_reset
);
    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // cycles since the load strobe pin was high, saturating
    logic [3:0] le_age;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) le_age <= 4'hf;
        else if (load_enable) le_age <= 4'h0;
        else if (le_age != 4'hf) le_age <= le_age + 4'h1;
    end
    chk_write_cause:
    assert property (($changed(power) || $changed(level_cal_target)
        || $changed(int_divide_word) || $changed(subunit_divide_word)
        || $changed(test_bus_select)) |-> le_age < 4'hc)
        else $error("register output moved without a write");
    chk_start_pulse:
    assert property (start != 4'h0 |=> start == 4'h0)
        else $error("start pulse longer than one cycle");
    chk_probe_float:
    assert property (analog_probe_pin_enable == (test_bus_select != 15'h0))
        else $error("probe enable disagrees with test select");
    chk_soft_clear:
    assert property (device_soft_reset |=> power == 5'h0
        && level_cal_target == 8'h0 && int_divide_word == 12'h0)
        else $error("registers not held clear in master reset");
    chk_return_cause:
    assert property (ramp_return_initial |-> !ramp_on
        && ($past(ramp_on) || $past(ramp_on, 2)))
        else $error("return pulse without a running ramp");
    chk_trigger_off:
    assert property ($fell(trigger_pin) && ramp_on |-> ##[1:6] !ramp_on)
        else $error("trigger fall did not stop ramp");
    chk_ramp_rise:
    assert property ($rose(ramp_on) |-> le_age < 4'hc)
        else $error("ramp started without a write");
    chk_conv_cause:
    assert property (converter_sample_tick |-> ref_div_tick
        || $past(ref_div_tick) || $past(ref_div_tick, 2))
        else $error("sample tick without reference tick");
    cover property (start.converter_start);
    cover property (ramp_return_initial);
    cover property (device_soft_reset);
endmodule
bind rtc_ctrl_regs rtc_regs_chk chk (.clk, .rst, .load_enable,
    .trigger_pin, .ref_div_tick, .analog_probe_pin_enable, .power,
    .start, .level_cal_target, .converter_sample_tick, .test_bus_select,
    .ramp_on, .ramp_return_initial, .int_divide_word,
    .subunit_divide_word, .device_soft_reset);

/* verif/rtc_ctrl_regs_test.sv */
`timescale 1ns/100ps
module rtc_ctrl_regs_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic trigger_pin = 1'b0;
    logic ref_div_tick = 1'b0;
    logic pfd_tick = 1'b0;
    logic serial_clk, serial_data, load_enable, readback_data_out;
    logic readback_level_high, diag_select_pin, analog_probe_pin_enable;
    logic converter_sample_tick, ramp_on, ramp_return_initial;
    logic device_soft_reset, cal_timestep_tick;
    rtc_pkg::rtc_power_type power;
    rtc_pkg::rtc_start_type start;
    logic [7:0] level_cal_target;
    logic [1:0] converter_average;
    logic [14:0] test_bus_select;
    logic [11:0] int_divide_word, cal_timestep_divider;
    logic [24:0] subunit_divide_word;
    logic [31:0] n_mismatch = 32'h0;
    logic [31:0] checked = 32'h0;
    logic [31:0] n_conv = 32'h0;
    logic [31:0] n_step = 32'h0;
    logic [31:0] n_ret = 32'h0;
    logic [3:0] seen = 4'h0;
    logic [31:0] n_diag = 32'h0;
    logic [31:0] rb = 32'h0;
    int hp = 3;
    always #5 clk = ~clk;
    rtc_host_model host (.clk, .serial_clk, .serial_data, .load_enable);
    rtc_ctrl_regs dut (.clk, .rst, .serial_clk, .serial_data,
        .load_enable, .trigger_pin, .ref_div_tick, .pfd_tick,
        .readback_data_out, .readback_level_high, .diag_select_pin,
        .analog_probe_pin_enable, .power, .start, .level_cal_target,
        .converter_average, .converter_sample_tick, .test_bus_select,
        .ramp_on, .ramp_return_initial, .int_divide_word,
        .subunit_divide_word, .device_soft_reset, .cal_timestep_divider,
        .cal_timestep_tick);
    // ********************************
    // monitors and helpers
    // ********************************
    // pulses are counted here so a fixed wait cannot miss them
    always @(posedge clk) begin
        seen = seen | start;
        n_conv = n_conv + 32'(converter_sample_tick);
        n_step = n_step + 32'(cal_timestep_tick);
        n_ret = n_ret + 32'(ramp_return_initial);
        n_diag = n_diag + 32'(diag_select_pin);
    end
    // readback bit is taken as the host lowers its clock
    always @(negedge serial_clk) begin
        rb = {rb[30:0], readback_data_out};
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 32'h1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 32'h1;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] w);
        host.send(w, hp);
        repeat (12) @(posedge clk);
        #1;
    endtask
    task automatic stop_test;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 32'h0 && checked != 32'h0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ********************************
    // scenarios
    // ********************************
    task automatic t_power;
        int b [5] = '{10, 8, 6, 7, 5};
        chk(32'({power, int_divide_word, ramp_on}), 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(32'h1 << b[i]);
            chk(32'(power), 32'h10 >> i);
        end
    endtask
    task automatic t_start;
        logic [31:0] w [4] = '{32'h0800, 32'h1000, 32'h0200, 32'h8002};
        for (int i = 0; i < 4; i++) begin
            seen = 4'h0;
            wr(w[i]);
            chk(32'(seen), 32'h8 >> i);
        end
    endtask
    task automatic t_fields;
        wr(32'h0000_14a1);
        chk(32'(level_cal_target), 32'ha5);
        wr(32'h0000_6062);
        chk(32'(converter_average), 32'h3);
        wr(32'h0000_1803);
        chk(32'({diag_select_pin, readback_level_high}), 32'h3);
        wr(32'h0008_0024);
        chk(32'(test_bus_select), 32'h4001);
        chk(32'(analog_probe_pin_enable), 32'h1);
        wr(32'h0000_0004);
        chk(32'(analog_probe_pin_enable), 32'h0);
        chk(rb, 32'h0000_0200);
        wr(32'h0080_0007);
        chk(32'(cal_timestep_divider), 32'h800);
    endtask
    task automatic t_ramp;
        logic [31:0] r0;
        r0 = n_ret;
        wr(32'h2096_0005);
        chk(32'({ramp_on, int_divide_word}), 32'h104b);
        trigger_pin = 1'b1;
        repeat (6) @(posedge clk);
        #1 trigger_pin = 1'b0;
        repeat (8) @(posedge clk);
        #1 chk(32'(ramp_on), 32'h0);
        chk(n_ret - r0, 32'h1);
        wr(32'h2096_0005);
        chk(32'(ramp_on), 32'h1);
        wr(32'h0000_f003);
        wr(32'h0000_0024);
        chk(32'(diag_select_pin), 32'h1);
        wr(32'h0003_5786);
        chk(32'(subunit_divide_word), 32'h0);
        wr(32'h0096_0005);
        chk(n_ret - r0, 32'h2);
        chk(32'(diag_select_pin), 32'h0);
        wr(32'h1ffe_b4a5);
        chk(32'(subunit_divide_word), 32'({12'h5a5, 13'h1abc}));
        chk(32'(int_divide_word), 32'hfff);
        wr(32'hffff_ffe8);
        wr(32'hffff_ffff);
        chk(32'({int_divide_word, level_cal_target}), 32'hfffa5);
    endtask
    task automatic t_ticks;
        logic [31:0] c0, s0, d0;
        wr(32'h0000_4007);
        wr(32'h0000_2003);
        d0 = n_diag;
        c0 = n_conv;
        s0 = n_step;
        for (int i = 0; i < 12; i++) begin
            ref_div_tick = 1'b1;
            pfd_tick = 1'b1;
            @(posedge clk);
            #1 ref_div_tick = 1'b0;
            pfd_tick = 1'b0;
            @(posedge clk);
            #1;
        end
        repeat (4) @(posedge clk);
        #1 chk(n_conv - c0, 32'h4);
        chk(n_step - s0, 32'h3);
        chk(n_diag - d0, 32'h4);
    endtask
    task automatic t_master;
        hp = 6;
        wr(32'h0000_0400);
        wr(32'h0200_0007);
        chk(32'({device_soft_reset, power}), 32'h20);
        chk(32'(int_divide_word), 32'h0);
        wr(32'h0000_0400);
        chk(32'(power), 32'h0);
        wr(32'h0000_0007);
        wr(32'h0000_0400);
        chk(32'({device_soft_reset, power}), 32'h10);
        hp = 3;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        t_power();
        t_start();
        t_fields();
        t_ramp();
        t_ticks();
        t_master();
        stop_test();
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch = n_mismatch + 32'h1;
        stop_test();
    end
endmodule
